// File: logic/timer2_control_and_cascade.sv
// Summary of operation
// R01: count source bit 0 counts oscillator/12, or oscillator/2 as baud generator.
// R02: count source bit 1 counts falling edges on the external count pin.
// R03: timer 2 counts while run is 1; while 0 it stops counting, but an external edge in auto-reload mode still reloads it.
// R04: external control pin ignored unless external enable is 1.
// R05: falling edge on external control pin with enable sets external flag.
// R06: external flag requests timer-2 interrupt; only software clears it.
// R07: carry in auto-reload or capture mode sets the overflow flag.
// R08: overflow flag requests timer-2 interrupt; only software clears it.
// R09: cascade bit chains timers 0 and 1 into one 32-bit counter.
// R10: carry of the 32-bit chain sets the timer-1 overflow flag.
// R11: watchdog mode plus timer-1 flag set resets the CPU to address 0.
// R12: timer-1 flag set on carry, cleared automatically when serviced.
// R13: capture/reload bit picks capture or auto reload unless serial clocking.
// R14: either serial clock bit makes the carry clock serial modes 1 and 3.
`timescale 1ns/100ps
`default_nettype none
module timer2_control_and_cascade #(
  parameter int CNT_W = timer2_pkg::TIMER_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer2_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer2_count_pin,
  input wire logic timer2_external_control_pin,
  input wire logic [1:0] serial_mode,
  input wire logic timer1_irq_ack,
  output logic timer2_irq,
  output logic timer1_irq,
  output logic cpu_reset,
  output logic serial_tx_clk,
  output logic serial_rx_clk,
  output logic irq
);
  timer2_pkg::apb_state_t state_q;
  timer2_pkg::t2_control_t ctl_q;
  timer2_pkg::io_options_t opt_q;
  logic [2:0] t01_ctl_q;
  logic [2*CNT_W-1:0] t01_cnt_q;
  logic [CNT_W-1:0] t2_cnt_q;
  logic [CNT_W-1:0] t2_reload_q;
  logic [timer2_pkg::IRQ_W-1:0] status_q;
  logic [timer2_pkg::IRQ_W-1:0] status_d;
  logic [timer2_pkg::IRQ_W-1:0] mask_q;
  logic [3:0] div_q;
  logic [31:0] rdata_d;
  logic addr_ok;
  logic done;
  logic wr_go;
  logic rd_go;
  logic [1:0] pin_fall;
  logic cnt_fall;
  logic ext_fall;
  logic tick12;
  logic tick2;
  logic baud;
  logic capture_mode;
  logic reload_mode;
  logic t2_tick;
  logic t2_step;
  logic t2_carry;
  logic ext_evt;
  logic ovf_set;
  logic t0_step;
  logic t0_carry;
  logic t1_step;
  logic t1_carry;
  logic wdog_evt;
  logic serial_carry_mode;
  logic ctl_wr;
  logic opt_wr;
  logic t01c_wr;
  logic t01_wr;
  logic t2_cnt_wr;
  logic t2_rl_wr;
  logic mask_wr;
  logic ovf_d;
  logic ext_d;
  logic tf1_d;

  pin_sync #(
    .W(2)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin({timer2_external_control_pin, timer2_count_pin}),
    .level(),
    .fall(pin_fall)
  );

  assign cnt_fall = pin_fall[0];
  assign ext_fall = pin_fall[1];

  // apb slave: one wait state, answer registered
  assign done = psel & penable & pready;
  assign wr_go = done & pwrite;
  assign rd_go = done & ~pwrite;
  assign ctl_wr = wr_go && paddr == timer2_pkg::OFS_TIMER2_CONTROL;
  assign opt_wr = wr_go && paddr == timer2_pkg::OFS_IO_AND_TIMER_OPTIONS;
  assign t01_wr = wr_go && paddr == timer2_pkg::OFS_TIMER01_COUNT;
  assign t01c_wr = wr_go && paddr == timer2_pkg::OFS_TIMER01_CONTROL;
  assign t2_cnt_wr = wr_go && paddr == timer2_pkg::OFS_TIMER2_COUNT;
  assign t2_rl_wr = wr_go && paddr == timer2_pkg::OFS_TIMER2_RELOAD;
  assign mask_wr = wr_go && paddr == timer2_pkg::OFS_IRQ_MASK;

  always_comb begin
    rdata_d = 32'h0;
    addr_ok = 1'b1;
    unique case (paddr)
      timer2_pkg::OFS_TIMER2_CONTROL: rdata_d[7:0] = ctl_q;
      timer2_pkg::OFS_IO_AND_TIMER_OPTIONS: rdata_d[7:6] = opt_q;
      timer2_pkg::OFS_TIMER01_COUNT: rdata_d[2*CNT_W-1:0] = t01_cnt_q;
      timer2_pkg::OFS_TIMER01_CONTROL: rdata_d[2:0] = t01_ctl_q;
      timer2_pkg::OFS_TIMER2_COUNT: rdata_d[CNT_W-1:0] = t2_cnt_q;
      timer2_pkg::OFS_TIMER2_RELOAD: rdata_d[CNT_W-1:0] = t2_reload_q;
      timer2_pkg::OFS_IRQ_STATUS: rdata_d[timer2_pkg::IRQ_W-1:0] = status_q;
      timer2_pkg::OFS_IRQ_MASK: rdata_d[timer2_pkg::IRQ_W-1:0] = mask_q;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= timer2_pkg::APB_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      unique case (state_q)
        timer2_pkg::APB_IDLE: begin
          if (psel && penable) begin
            state_q <= timer2_pkg::APB_ACK;
            pready <= 1'b1;
            pslverr <= ~addr_ok;
            prdata <= pwrite ? 32'h0 : rdata_d;
          end
        end
        timer2_pkg::APB_ACK: begin
          state_q <= timer2_pkg::APB_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
          prdata <= 32'h0;
        end
      endcase
    end
  end

  // shared prescaler; the /2 tick falls inside the /12 cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 4'h0;
    end else if (div_q == timer2_pkg::PRESCALE_INTERNAL - 4'h1) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign tick12 = div_q == timer2_pkg::PRESCALE_INTERNAL - 4'h1;
  assign tick2 = (div_q % timer2_pkg::PRESCALE_BAUD) == timer2_pkg::PRESCALE_BAUD - 4'h1;

  // R13 mode select
  assign baud = ctl_q.serial_rx_clock_from_timer2 | ctl_q.serial_tx_clock_from_timer2;
  assign capture_mode = ~baud & ctl_q.timer2_capture_reload_select;
  assign reload_mode = ~baud & ~ctl_q.timer2_capture_reload_select;

  // R01 R02 count source
  assign t2_tick = ctl_q.timer2_count_source_select ? cnt_fall : (baud ? tick2 : tick12);
  // R03 run gating
  assign t2_step = ctl_q.timer2_run & t2_tick;
  assign t2_carry = t2_step && t2_cnt_q == {CNT_W{1'b1}};
  // R04 external pin only while enabled
  assign ext_evt = ctl_q.timer2_external_enable & ext_fall;
  // R07 no overflow flag in baud generator mode
  assign ovf_set = t2_carry & ~baud;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      t2_cnt_q <= {CNT_W{1'b0}};
    end else if (t2_cnt_wr) begin
      t2_cnt_q <= pwdata[CNT_W-1:0];
    end else if (t2_carry) begin
      t2_cnt_q <= capture_mode ? {CNT_W{1'b0}} : t2_reload_q;
    end else if (t2_step) begin
      t2_cnt_q <= t2_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (ext_evt && reload_mode) begin
      t2_cnt_q <= t2_reload_q;
    end
  end

  // R13 capture on external edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      t2_reload_q <= {CNT_W{1'b0}};
    end else if (t2_rl_wr) begin
      t2_reload_q <= pwdata[CNT_W-1:0];
    end else if (ext_evt && capture_mode) begin
      t2_reload_q <= t2_cnt_q;
    end
  end

  // R05 R06 R07 R08 flags: hardware set beats a software clear
  always_comb begin
    ovf_d = ctl_wr ? pwdata[7] : ctl_q.timer2_overflow_flag;
    ext_d = ctl_wr ? pwdata[6] : ctl_q.timer2_external_edge_flag;
    ovf_d = ovf_d | ovf_set;
    ext_d = ext_d | ext_evt;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= timer2_pkg::T2_CONTROL_RST;
    end else begin
      if (ctl_wr) begin
        ctl_q[5:0] <= pwdata[5:0];
      end
      ctl_q.timer2_overflow_flag <= ovf_d;
      ctl_q.timer2_external_edge_flag <= ext_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opt_q <= timer2_pkg::IO_OPTIONS_RST;
    end else if (opt_wr) begin
      opt_q <= pwdata[7:6];
    end
  end

  // R14 baud ticks only for serial modes that take the timer carry
  assign serial_carry_mode = serial_mode == timer2_pkg::SERIAL_MODE1
                             || serial_mode == timer2_pkg::SERIAL_MODE3;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_tx_clk <= 1'b0;
      serial_rx_clk <= 1'b0;
    end else begin
      serial_tx_clk <= t2_carry & ctl_q.serial_tx_clock_from_timer2 & serial_carry_mode;
      serial_rx_clk <= t2_carry & ctl_q.serial_rx_clock_from_timer2 & serial_carry_mode;
    end
  end

  // R09 timers 0 and 1; in cascade timer 1 runs off timer 0's carry
  assign t0_step = tick12 & t01_ctl_q[timer2_pkg::T01_RUN0_BIT];
  assign t0_carry = t0_step && t01_cnt_q[CNT_W-1:0] == {CNT_W{1'b1}};
  assign t1_step = opt_q.cascade_32bit_enable ? t0_carry
                   : (tick12 & t01_ctl_q[timer2_pkg::T01_RUN1_BIT]);
  // R10 in cascade this is the 32-bit carry
  assign t1_carry = t1_step && t01_cnt_q[2*CNT_W-1:CNT_W] == {CNT_W{1'b1}};
  // R11 watchdog hit
  assign wdog_evt = t1_carry & opt_q.watchdog_mode_enable;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      t01_cnt_q <= {(2*CNT_W){1'b0}};
    end else if (t01_wr) begin
      t01_cnt_q <= pwdata[2*CNT_W-1:0];
    end else begin
      if (t0_step) begin
        t01_cnt_q[CNT_W-1:0] <= t01_cnt_q[CNT_W-1:0] + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (t1_step) begin
        t01_cnt_q[2*CNT_W-1:CNT_W] <= t01_cnt_q[2*CNT_W-1:CNT_W]
                                      + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // R12 set on carry wins over service and software clear
  always_comb begin
    tf1_d = t01_ctl_q[timer2_pkg::T01_FLAG1_BIT];
    if (t01c_wr) begin
      tf1_d = pwdata[timer2_pkg::T01_FLAG1_BIT];
    end
    if (timer1_irq_ack) begin
      tf1_d = 1'b0;
    end
    tf1_d = tf1_d | t1_carry;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      t01_ctl_q <= timer2_pkg::T01_CONTROL_RST;
    end else begin
      if (t01c_wr) begin
        t01_ctl_q[timer2_pkg::T01_RUN1_BIT:0] <= pwdata[timer2_pkg::T01_RUN1_BIT:0];
      end
      t01_ctl_q[timer2_pkg::T01_FLAG1_BIT] <= tf1_d;
    end
  end

  // R11 one-cycle cpu reset request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_reset <= 1'b0;
    end else begin
      cpu_reset <= wdog_evt;
    end
  end

  // sticky status, read clears; an event in the clearing cycle survives
  always_comb begin
    status_d = status_q;
    if (rd_go && paddr == timer2_pkg::OFS_IRQ_STATUS) begin
      status_d = {timer2_pkg::IRQ_W{1'b0}};
    end
    status_d[timer2_pkg::IRQ_T2_OVF_BIT] = status_d[timer2_pkg::IRQ_T2_OVF_BIT] | ovf_set;
    status_d[timer2_pkg::IRQ_T2_EXT_BIT] = status_d[timer2_pkg::IRQ_T2_EXT_BIT] | ext_evt;
    status_d[timer2_pkg::IRQ_T1_OVF_BIT] = status_d[timer2_pkg::IRQ_T1_OVF_BIT] | t1_carry;
    status_d[timer2_pkg::IRQ_WDOG_BIT] = status_d[timer2_pkg::IRQ_WDOG_BIT] | wdog_evt;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= timer2_pkg::IRQ_RST;
      mask_q <= timer2_pkg::IRQ_RST;
      irq <= 1'b0;
    end else begin
      status_q <= status_d;
      if (mask_wr) begin
        mask_q <= pwdata[timer2_pkg::IRQ_W-1:0];
      end
      irq <= |(status_d & (mask_wr ? pwdata[timer2_pkg::IRQ_W-1:0] : mask_q));
    end
  end

  // R06 R08 request follows the flags
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer2_irq <= 1'b0;
      timer1_irq <= 1'b0;
    end else begin
      timer2_irq <= ovf_d | ext_d;
      timer1_irq <= tf1_d;
    end
  end

  internal_div_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R01
    (ctl_q.timer2_run && !ctl_q.timer2_count_source_select && !baud && !tick12
     && !t2_cnt_wr && !ext_evt) |=> $stable(t2_cnt_q))
    else $error("timer 2 moved without a divide-by-12 tick");

  ext_source_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R02
    (ctl_q.timer2_count_source_select && ctl_q.timer2_run && cnt_fall && !t2_carry
     && !t2_cnt_wr) |=> t2_cnt_q == $past(t2_cnt_q) + 16'h1)
    else $error("external count edge not counted");

  run_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R03
    (!ctl_q.timer2_run && !t2_cnt_wr && !ext_evt) |=> $stable(t2_cnt_q))
    else $error("timer 2 counted while stopped");

  ext_ignored_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R04
    (!ctl_q.timer2_external_enable && !ctl_q.timer2_external_edge_flag && !ctl_wr)
    |=> !ctl_q.timer2_external_edge_flag)
    else $error("external flag set while disabled");

  ext_flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R05
    (ctl_q.timer2_external_enable && ext_fall) |=> ctl_q.timer2_external_edge_flag
    ##1 timer2_irq)
    else $error("external edge did not raise flag and request");

  overflow_set_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R07
    (t2_carry && !baud) |=> ctl_q.timer2_overflow_flag && timer2_irq)
    else $error("timer 2 carry did not set overflow flag");

  cascade_carry_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
    (opt_q.cascade_32bit_enable && t0_step && !t01_wr
     && t01_cnt_q == {(2*CNT_W){1'b1}}) |=> t01_ctl_q[timer2_pkg::T01_FLAG1_BIT]
     && t01_cnt_q == {(2*CNT_W){1'b0}})
    else $error("32-bit carry did not set timer 1 flag");

  watchdog_reset_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R11
    (opt_q.watchdog_mode_enable && t1_carry) |=> cpu_reset ##1 !cpu_reset)
    else $error("watchdog did not pulse cpu reset");

  flag1_service_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
    (timer1_irq_ack && !t1_carry) |=> !t01_ctl_q[timer2_pkg::T01_FLAG1_BIT] ##1 !timer1_irq)
    else $error("timer 1 flag not cleared by service");

  capture_take_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
    (ext_evt && capture_mode && !t2_rl_wr) |=> t2_reload_q == $past(t2_cnt_q))
    else $error("capture did not latch the count");

  baud_tick_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R14
    (t2_carry && ctl_q.serial_tx_clock_from_timer2 && serial_carry_mode)
    |=> serial_tx_clk && (ctl_q.timer2_overflow_flag == $past(ctl_q.timer2_overflow_flag)
    || $past(ctl_wr)))
    else $error("baud carry did not clock the transmitter");

endmodule
`default_nettype wire

// File: pkg/timer2_pkg.sv
`default_nettype none
package timer2_pkg;

  localparam int ADDR_W = 8;
  localparam int TIMER_W = 16;

  localparam logic [7:0] OFS_TIMER2_CONTROL = 8'hc8;
  localparam logic [7:0] OFS_IO_AND_TIMER_OPTIONS = 8'hf8;
  localparam logic [7:0] OFS_TIMER01_COUNT = 8'h00;
  localparam logic [7:0] OFS_TIMER01_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TIMER2_COUNT = 8'h08;
  localparam logic [7:0] OFS_TIMER2_RELOAD = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // timer 0/1 control fields
  localparam int T01_RUN0_BIT = 0;
  localparam int T01_RUN1_BIT = 1;
  localparam int T01_FLAG1_BIT = 2;

  // interrupt status / mask layout
  localparam int IRQ_W = 4;
  localparam int IRQ_T2_OVF_BIT = 0;
  localparam int IRQ_T2_EXT_BIT = 1;
  localparam int IRQ_T1_OVF_BIT = 2;
  localparam int IRQ_WDOG_BIT = 3;

  // prescaler divisors, cycles of core_clk
  localparam logic [3:0] PRESCALE_INTERNAL = 4'hc;
  localparam logic [3:0] PRESCALE_BAUD = 4'h2;

  localparam logic [1:0] SERIAL_MODE1 = 2'h1;
  localparam logic [1:0] SERIAL_MODE3 = 2'h3;

  typedef struct packed {
    logic timer2_overflow_flag;
    logic timer2_external_edge_flag;
    logic serial_rx_clock_from_timer2;
    logic serial_tx_clock_from_timer2;
    logic timer2_external_enable;
    logic timer2_run;
    logic timer2_count_source_select;
    logic timer2_capture_reload_select;
  } t2_control_t;

  typedef struct packed {
    logic watchdog_mode_enable;
    logic cascade_32bit_enable;
  } io_options_t;

  localparam t2_control_t T2_CONTROL_RST = 8'h00;
  localparam io_options_t IO_OPTIONS_RST = 2'h0;
  localparam logic [2:0] T01_CONTROL_RST = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACK = 2'b10
  } apb_state_t;

endpackage
`default_nettype wire

// File: logic/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] fall
);
  // per pin: two-flop synchroniser, then a third flop for edge detection
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      logic meta_q;
      logic sync_q;
      logic prev_q;
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          prev_q <= 1'b1;
        end else begin
          meta_q <= pin[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign level[i] = sync_q;
      assign fall[i] = prev_q & ~sync_q;
    end
  endgenerate
endmodule
`default_nettype wire

// File: bench/ext_pins.sv
`timescale 1ns/100ps
`default_nettype none
module ext_pins (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic fire_count,
  input wire logic fire_ctrl,
  output logic count_pin,
  output logic ctrl_pin,
  output logic busy
);
  logic [2:0] cnt_q;

  // falling pin edges
  // pins idle high like pulled-up lines; each pulse is 3 cycles low, 4 high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_pin <= 1'b1;
      ctrl_pin <= 1'b1;
      cnt_q <= 3'h0;
      busy <= 1'b0;
    end else if (cnt_q == 3'h0) begin
      if (fire_count | fire_ctrl) begin
        count_pin <= ~fire_count;
        ctrl_pin <= ~fire_ctrl;
        cnt_q <= 3'h6;
        busy <= 1'b1;
      end
    end else begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h4) begin
        count_pin <= 1'b1;
        ctrl_pin <= 1'b1;
      end
      if (cnt_q == 3'h1) begin
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; $display("CHECK FAILED %0t got %h exp %h", $time, got, exp); end end
module tb_top;
  typedef struct packed {logic rd; logic [31:0] d; logic e;} apb_exp_t;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rng, v;
  logic [1:0] serial_mode;
  logic timer1_irq_ack, timer2_irq, timer1_irq, cpu_reset, serial_tx_clk, serial_rx_clk, irq;
  logic fire_count, fire_ctrl, count_pin, ctrl_pin, pin_busy;
  int err_count, n_tests, tx_n, rx_n, rst_n, n;
  apb_exp_t exp_q[$];
  apb_exp_t cur;

  timer2_control_and_cascade dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer2_count_pin(count_pin),
    .timer2_external_control_pin(ctrl_pin), .serial_mode(serial_mode),
    .timer1_irq_ack(timer1_irq_ack), .timer2_irq(timer2_irq), .timer1_irq(timer1_irq),
    .cpu_reset(cpu_reset), .serial_tx_clk(serial_tx_clk), .serial_rx_clk(serial_rx_clk),
    .irq(irq));

  ext_pins pins (.core_clk(core_clk), .rst_b(rst_b), .fire_count(fire_count),
    .fire_ctrl(fire_ctrl), .count_pin(count_pin), .ctrl_pin(ctrl_pin), .busy(pin_busy));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
    end
  endfunction

  task automatic wrap_up();
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  // every answer is judged here against the oldest note of the driver
  always @(posedge core_clk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        cur = exp_q.pop_front();
        `CHK(pslverr, cur.e)
        if (cur.rd) `CHK(prdata, cur.d)
      end
    end
    if (serial_tx_clk === 1'b1) tx_n++;
    if (serial_rx_clk === 1'b1) rx_n++;
    if (cpu_reset === 1'b1) rst_n++;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    int i;
    begin
      @(posedge core_clk);
      exp_q.push_back({~w, ed, ee});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      i = 0;
      do begin
        @(posedge core_clk);
        i++;
      end while (pready !== 1'b1 && i < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) `CHK(1'b0, 1'b1)
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask

  task automatic wait_sig(input int which, output int cyc);
    logic s;
    begin
      cyc = 0;
      s = 1'b0;
      while (s !== 1'b1 && cyc < 400) begin
        @(posedge core_clk);
        cyc++;
        case (which)
          0: s = timer2_irq;
          1: s = timer1_irq;
          2: s = serial_tx_clk;
          default: s = cpu_reset;
        endcase
      end
      `CHK(s, 1'b1)
    end
  endtask

  task automatic pulse(input logic cnt);
    begin
      @(posedge core_clk);
      if (cnt) fire_count <= 1'b1;
      else fire_ctrl <= 1'b1;
      @(posedge core_clk);
      fire_count <= 1'b0;
      fire_ctrl <= 1'b0;
      repeat (10) @(posedge core_clk);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  initial begin
    #(40 * 6000);
    err_count++;
    $display("CHECK FAILED %0t run took too long", $time);
    wrap_up();
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    serial_mode = 2'h0;
    timer1_irq_ack = 1'b0;
    fire_count = 1'b0;
    fire_ctrl = 1'b0;
    rng = 32'hae5a;
    err_count = 0;
    n_tests = 0;
    tx_n = 0;
    rx_n = 0;
    rst_n = 0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(8'hc8, 32'h0);
    rd(8'hf8, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h20, 32'hff, 32'h0, 1'b1);
    done("registers");
    wr(8'h14, 32'h2);
    pulse(1'b0);
    @(negedge core_clk);
    `CHK(timer2_irq, 1'b0)
    rd(8'hc8, 32'h0);
    wr(8'hc8, 32'h8);
    pulse(1'b0);
    @(negedge core_clk);
    `CHK(timer2_irq, 1'b1)
    `CHK(irq, 1'b1)
    rd(8'hc8, 32'h48);
    rd(8'h10, 32'h2);
    rd(8'h10, 32'h0);
    @(negedge core_clk);
    `CHK(irq, 1'b0)
    `CHK(timer2_irq, 1'b1)
    wr(8'hc8, 32'h0);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(timer2_irq, 1'b0)
    done("external edge");
    rng = xs(rng);
    v = {20'h0, rng[11:0]};
    wr(8'h08, v);
    repeat (30) @(posedge core_clk);
    rd(8'h08, v);
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'hfff0);
    wr(8'hc8, 32'h4);
    wait_sig(0, n);
    `CHK(n >= 175 && n <= 205, 1'b1)
    rd(8'hc8, 32'h84);
    wr(8'hc8, 32'h0);
    done("overflow");
    wr(8'h08, 32'h0);
    wr(8'hc8, 32'h6);
    rng = xs(rng);
    repeat (1 + rng[1:0]) pulse(1'b1);
    wr(8'hc8, 32'h0);
    rd(8'h08, 32'(1 + rng[1:0]));
    done("external count");
    wr(8'hc8, 32'h9);
    pulse(1'b0);
    rd(8'h0c, 32'(1 + rng[1:0]));
    rd(8'h08, 32'(1 + rng[1:0]));
    wr(8'hc8, 32'h0);
    done("capture");
    serial_mode <= timer2_pkg::SERIAL_MODE1;
    wr(8'h08, 32'hfffc);
    wr(8'hc8, 32'h14);
    wait_sig(2, n);
    `CHK(n <= 14, 1'b1)
    rd(8'hc8, 32'h14);
    `CHK(rx_n, 0)
    wr(8'hc8, 32'h0);
    serial_mode <= 2'h0;
    tx_n = 0;
    wr(8'h08, 32'hfffc);
    wr(8'hc8, 32'h14);
    repeat (40) @(posedge core_clk);
    `CHK(tx_n, 0)
    wr(8'hc8, 32'h0);
    serial_mode <= timer2_pkg::SERIAL_MODE3;
    rx_n = 0;
    tx_n = 0;
    wr(8'h08, 32'hfffc);
    wr(8'hc8, 32'h24);
    repeat (40) @(posedge core_clk);
    `CHK(rx_n, 1)
    `CHK(tx_n, 0)
    wr(8'hc8, 32'h0);
    done("baud");
    wr(8'hf8, 32'h40);
    rd(8'hf8, 32'h40);
    wr(8'h00, 32'hffff_fffe);
    wr(8'h04, 32'h1);
    wait_sig(1, n);
    rd(8'h04, 32'h5);
    `CHK(rst_n, 0)
    @(posedge core_clk);
    timer1_irq_ack <= 1'b1;
    @(posedge core_clk);
    timer1_irq_ack <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(timer1_irq, 1'b0)
    done("cascade");
    wr(8'h04, 32'h0);
    wr(8'hf8, 32'hc0);
    wr(8'h00, 32'hffff_ffff);
    wr(8'h04, 32'h1);
    wait_sig(3, n);
    repeat (5) @(posedge core_clk);
    `CHK(rst_n, 1)
    done("watchdog");
    wrap_up();
  end
endmodule
`default_nettype wire
